// ### dv/acd_mem_model.sv
// data memory model seen by the external move address
`timescale 1ns/10ps
module acd_mem_model
(
  input wire logic clock_i,
  input wire logic [15:0] xaddr_i,
  input wire logic xrd_i,
  input wire logic xwr_i,
  output logic [15:0] last_addr_o,
  output logic last_wr_o,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [0:255];
  initial
  begin
    last_addr_o = 16'h0000;
    last_wr_o = 1'b0;
    rd_data_o = 8'h00;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
  end
  // ************************************************************
  // access capture
  // ************************************************************
  // answers one clock after the strobe is sampled, inside any stretch window
  always @(posedge clock_i)
  begin
    if (xrd_i | xwr_i)
    begin
      last_addr_o <= xaddr_i;
      last_wr_o <= xwr_i;
    end
    // released bus shows a changing pattern
    rd_data_o <= xrd_i ? mem[xaddr_i[7:0]] : ~rd_data_o;
  end
endmodule

// ### dv/testbench.sv
// self-checking bench for the instruction decode block
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  $display("Error %0t: got %h expected %h", $time, a, b); n_errors++; end end
module testbench;
  logic clock_i, rst_n_i, start, spec_wr;
  logic [7:0] opcode, op1, op2, r0, r1, spec_addr, spec_wdata, n_last, n_tick;
  logic [15:0] pc, data_ptr;
  logic [2:0] stretch;
  logic seen_busy, seen_rd, seen_wr, after_x;
  int n_errors, tests_run;
  logic [7:0] spec_rdata;
  logic busy, done, tick, ptr_sel, ub, up, xrd, xwr, phit, m_wr;
  acd_pkg::acd_class_t cls;
  logic [1:0] bytes;
  logic [3:0] cycles;
  logic [2:0] bank;
  logic [15:0] xaddr, relt, abst, longt, m_addr;
  acd_decode #(.CLK_PER_ICYC(4), .PERIPH_BASE(16'h8000)) i_dut (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .start_i(start), .opcode_i(opcode), .operand1_i(op1),
    .operand2_i(op2), .pc_i(pc), .data_ptr_i(data_ptr), .r0_i(r0), .r1_i(r1),
    .stretch_i(stretch), .spec_wr_i(spec_wr), .spec_addr_i(spec_addr),
    .spec_wdata_i(spec_wdata), .spec_rdata_o(spec_rdata), .busy_o(busy), .done_o(done),
    .icyc_tick_o(tick), .op_class_o(cls), .byte_count_o(bytes), .cycle_count_o(cycles),
    .bank_sel_o(bank), .ptr_sel_o(ptr_sel), .uses_bank_o(ub), .uses_ptr_o(up),
    .xaddr_o(xaddr), .xrd_o(xrd), .xwr_o(xwr), .periph_hit_o(phit),
    .rel_target_o(relt), .abs_target_o(abst), .long_target_o(longt));
  acd_mem_model i_mem (.clock_i(clock_i), .xaddr_i(xaddr), .xrd_i(xrd), .xwr_i(xwr),
    .last_addr_o(m_addr), .last_wr_o(m_wr), .rd_data_o());
  // ************************************************************
  // clock, reset, watchdog
  // ************************************************************
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic exec(input logic [7:0] op, input logic [2:0] st, input logic poke);
    @(posedge clock_i);
    opcode <= op;
    stretch <= st;
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    @(negedge clock_i);
    seen_busy = busy;
    seen_rd = xrd;
    seen_wr = xwr;
    n_last = 8'h01;
    n_tick = {7'h0, tick};
    while (done !== 1'b1 && n_last < 8'h40)
    begin
      @(posedge clock_i);
      if (poke && n_last == 8'h01)
      begin
        start <= 1'b1;
        opcode <= 8'h38;
      end
      if (poke && n_last == 8'h02)
      begin
        start <= 1'b0;
        opcode <= op;
      end
      @(negedge clock_i);
      n_last = n_last + 8'h01;
      n_tick = n_tick + {7'h0, tick};
    end
    @(negedge clock_i);
    after_x = xrd | xwr;
    `CHK(busy, 1'b0)
    `CHK(seen_busy, 1'b1)
  endtask
  task automatic check_op(input logic [7:0] op, input acd_pkg::acd_class_t c,
    input logic [1:0] b, input logic [3:0] cy);
    exec(op, 3'h0, 1'b0);
    `CHK(cls, c)
    `CHK(bytes, b)
    `CHK(cycles, cy)
    `CHK(n_last, {2'h0, cy, 2'h0})
    `CHK(n_tick, {4'h0, cy})
  endtask
  task automatic spec_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    spec_wr <= 1'b1;
    spec_addr <= a;
    spec_wdata <= d;
    @(posedge clock_i);
    spec_wr <= 1'b0;
  endtask
  task automatic spec_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    spec_addr <= a;
    @(posedge clock_i);
    @(negedge clock_i);
    `CHK(spec_rdata, exp)
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    `CHK(busy, 1'b0)
    `CHK(cls, acd_pkg::ACD_OTHER)
    `CHK(bytes, 2'h1)
    `CHK(cycles, 4'h1)
    spec_read(8'h92, 8'h00);
  endtask
  task automatic t_midreset();
    @(posedge clock_i);
    opcode <= 8'he0;
    stretch <= 3'h7;
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    `CHK({busy, xrd, xwr, phit}, 4'h0)
    `CHK(cycles, 4'h1)
    spec_read(8'h92, 8'h00);
    check_op(8'h9e, acd_pkg::ACD_ARITH, 2'h1, 4'h1);
  endtask
  task automatic t_table();
    check_op(8'h38, acd_pkg::ACD_ARITH, 2'h1, 4'h1);
    check_op(8'h3f, acd_pkg::ACD_ARITH, 2'h1, 4'h1);
    check_op(8'h9b, acd_pkg::ACD_ARITH, 2'h1, 4'h1);
    check_op(8'ha3, acd_pkg::ACD_ARITH, 2'h1, 4'h3);
    check_op(8'h53, acd_pkg::ACD_LOGIC, 2'h3, 4'h3);
    check_op(8'h6d, acd_pkg::ACD_LOGIC, 2'h1, 4'h1);
    check_op(8'h33, acd_pkg::ACD_LOGIC, 2'h1, 4'h1);
    check_op(8'h13, acd_pkg::ACD_LOGIC, 2'h1, 4'h1);
    check_op(8'h90, acd_pkg::ACD_MOVE, 2'h3, 4'h3);
    check_op(8'h93, acd_pkg::ACD_CODERD, 2'h1, 4'h3);
    check_op(8'h83, acd_pkg::ACD_CODERD, 2'h1, 4'h3);
    check_op(8'hc0, acd_pkg::ACD_MOVE, 2'h2, 4'h2);
    check_op(8'h76, acd_pkg::ACD_MOVE, 2'h2, 4'h2);
    `CHK(ptr_sel, 1'b0)
    check_op(8'h9e, acd_pkg::ACD_ARITH, 2'h1, 4'h1);
    `CHK(bank, 3'h6)
    `CHK(ub, 1'b1)
  endtask
  task automatic t_refused();
    exec(8'h85, 3'h0, 1'b1);
    `CHK(cls, acd_pkg::ACD_MOVE)
    `CHK(bytes, 2'h3)
    `CHK(n_last, 8'h0c)
  endtask
  task automatic t_xmove();
    spec_write(8'h92, 8'h5a);
    spec_write(8'h93, 8'h11);
    spec_read(8'h92, 8'h5a);
    spec_read(8'h93, 8'h00);
    @(posedge clock_i);
    r0 <= 8'hc4;
    r1 <= 8'h3c;
    exec(8'hf3, 3'h7, 1'b0);
    `CHK(xaddr, 16'h5a3c)
    `CHK(m_addr, 16'h5a3c)
    `CHK({seen_wr, seen_rd, m_wr}, 3'b101)
    `CHK(cycles, 4'h9)
    `CHK(n_last, 8'h24)
    `CHK(after_x, 1'b0)
    `CHK(cls, acd_pkg::ACD_XMOVE)
    `CHK(n_tick, 8'h09)
    `CHK(up, 1'b1)
    exec(8'hf2, 3'h0, 1'b0);
    `CHK(xaddr, 16'h5ac4)
    @(posedge clock_i);
    data_ptr <= 16'h9abc;
    exec(8'he0, 3'h0, 1'b0);
    `CHK(xaddr, 16'h9abc)
    `CHK({seen_rd, seen_wr, m_wr}, 3'b100)
    `CHK(cycles, 4'h2)
    `CHK(n_last, 8'h08)
    `CHK(phit, 1'b1)
    `CHK(after_x, 1'b0)
    `CHK(up, 1'b0)
    @(posedge clock_i);
    data_ptr <= 16'h7fff;
    exec(8'he0, 3'h1, 1'b0);
    `CHK(phit, 1'b0)
    `CHK(cycles, 4'h3)
  endtask
  task automatic t_targets();
    @(posedge clock_i);
    pc <= 16'h1234;
    op1 <= 8'hfe;
    op2 <= 8'h34;
    exec(8'h80, 3'h0, 1'b0);
    `CHK(relt, 16'h1232)
    @(posedge clock_i);
    op1 <= 8'h55;
    exec(8'h31, 3'h0, 1'b0);
    `CHK(abst, 16'h1155)
    @(posedge clock_i);
    op1 <= 8'h12;
    exec(8'h02, 3'h0, 1'b0);
    `CHK(longt, 16'h1234)
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    {start, spec_wr} = 2'h0;
    {opcode, op1, op2, r0, r1, spec_addr, spec_wdata} = '0;
    {pc, data_ptr, stretch} = '0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    t_reset();
    t_table();
    t_refused();
    t_xmove();
    t_midreset();
    t_targets();
    give_verdict();
  end
endmodule

// ### src/acd_consts.svh
// constants for the instruction decode block
`ifndef ACD_CONSTS_SVH
`define ACD_CONSTS_SVH
`define ACD_PAGE_SPEC_ADDR 8'h92
`define ACD_PAGE_RESET 8'h00
`define ACD_CLK_PERIOD_NS 100
`define ACD_ICYC_NS 400
`define ACD_CLK_PER_ICYC (`ACD_ICYC_NS / `ACD_CLK_PERIOD_NS)
`define ACD_XMOVE_BASE_CYC 4'h2
`define ACD_PERIPH_BASE 16'h8000
`define ACD_OP_ADDC_BANK 8'b0011_1???
`define ACD_OP_SUBB_BANK 8'b1001_1???
`define ACD_OP_XRL_BANK 8'b0110_1???
`define ACD_OP_INC_DATA_PTR 8'ha3
`define ACD_OP_ANL_DIR_IMM 8'h53
`define ACD_OP_RLC 8'h33
`define ACD_OP_RRC 8'h13
`define ACD_OP_MOV_DIR_DIR 8'h85
`define ACD_OP_MOV_PTR_IMM 8'h90
`define ACD_OP_CODE_VIA_PTR 8'h93
`define ACD_OP_CODE_PC 8'h83
`define ACD_OP_XRD_WIDE 8'he0
`define ACD_OP_XWR_PTR 8'b1111_001?
`define ACD_OP_PUSH 8'hc0
`define ACD_OP_MOV_IND_IMM 8'b0111_011?
`endif

// ### src/acd_decode.sv
// instruction decode, cycle sequencing and external address for the core
// Notes on behaviour
// RQ1: 8-bit pointer: page register high, R0/R1 low
// RQ2: 16-bit pointer: address from data pointer
// RQ3: opcodes decode to standard functions
// RQ4: peripheral window flagged; page register in special-function space
// RQ5: add-with-carry bank register 38-3F, 1/1
// RQ6: subtract-with-borrow bank register 98-9F, 1/1
// RQ7: increment data pointer A3, 1 byte 3 cycles
// RQ8: AND immediate to direct 53, 3/3
// RQ9: XOR bank register 68-6F, 1/1
// RQ10: rotate through carry 33 and 13, 1/1
// RQ11: move direct to direct 85, 3/3
// RQ12: load data pointer immediate 90, 3/3
// RQ13: code read via data pointer 93, 1/3
// RQ14: code read via program counter 83, 1/3
// RQ15: external read wide E0, 2-9 cycles
// RQ16: external write pointer F2-F3, 2-9 cycles
// RQ17: push direct C0, 2 bytes 2 cycles
// RQ18: immediate via pointer 76-77, 2/2
// RQ19: relative operand is signed offset byte
// RQ20: short target 11 bits, long 16 bits
// RQ21: instruction cycle lasts four clocks
// RQ22: execution one to nine instruction cycles
// RQ23: register index from low opcode bits
// RQ24: memory answers within stretch window
`timescale 1ns/10ps
`include "acd_consts.svh"
module acd_decode
#(
  parameter int CLK_PER_ICYC = `ACD_CLK_PER_ICYC,
  parameter logic [15:0] PERIPH_BASE = `ACD_PERIPH_BASE
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand1_i,
  input wire logic [7:0] operand2_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] data_ptr_i,
  input wire logic [7:0] r0_i,
  input wire logic [7:0] r1_i,
  input wire logic [2:0] stretch_i,
  input wire logic spec_wr_i,
  input wire logic [7:0] spec_addr_i,
  input wire logic [7:0] spec_wdata_i,
  output logic [7:0] spec_rdata_o,
  output logic busy_o,
  output logic done_o,
  output logic icyc_tick_o,
  output acd_pkg::acd_class_t op_class_o,
  output logic [1:0] byte_count_o,
  output logic [3:0] cycle_count_o,
  output logic [2:0] bank_sel_o,
  output logic ptr_sel_o,
  output logic uses_bank_o,
  output logic uses_ptr_o,
  output logic [15:0] xaddr_o,
  output logic xrd_o,
  output logic xwr_o,
  output logic periph_hit_o,
  output logic [15:0] rel_target_o,
  output logic [15:0] abs_target_o,
  output logic [15:0] long_target_o
);
  localparam int CW = $clog2(CLK_PER_ICYC);

  // ****************************************
  // decode of the incoming opcode
  // ****************************************
  acd_pkg::acd_class_t dec_class;
  logic [1:0] dec_bytes;
  logic [3:0] dec_cycles;
  logic dec_bank;
  logic dec_ptr;
  logic dec_xwrite;
  logic dec_xwide;
  logic [15:0] dec_xaddr;

  acd_len_table u_table
  (
    .opcode_i(opcode_i),
    .op_class_o(dec_class),
    .byte_count_o(dec_bytes),
    .cycle_count_o(dec_cycles),
    .uses_bank_o(dec_bank),
    .uses_ptr_o(dec_ptr),
    .xmove_write_o(dec_xwrite),
    .xmove_wide_o(dec_xwide)
  );

  logic [7:0] page_r;
  logic [7:0] page_nxt;

  acd_xaddr u_xaddr
  (
    .wide_i(dec_xwide),
    .ptr_sel_i(opcode_i[0]),
    .r0_i(r0_i),
    .r1_i(r1_i),
    .page_i(page_r),
    .data_ptr_i(data_ptr_i),
    .xaddr_o(dec_xaddr)
  );

  wire logic dec_is_x;
  wire logic [3:0] dec_total;
  wire logic [15:0] rel_sext;
  assign dec_is_x = (dec_class == acd_pkg::ACD_XMOVE);
  // stretch lengthens the external move from 2 up to 9 cycles
  assign dec_total = dec_is_x ? dec_cycles + {1'b0, stretch_i} : dec_cycles; // see RQ15 see RQ16
  assign rel_sext = {{8{operand1_i[7]}}, operand1_i}; // see RQ19

  // ****************************************
  // page register in special-function space
  // ****************************************
  wire logic page_hit;
  assign page_hit = (spec_addr_i == `ACD_PAGE_SPEC_ADDR); // see RQ4
  assign page_nxt = (spec_wr_i && page_hit) ? spec_wdata_i : page_r;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      page_r <= `ACD_PAGE_RESET;
      spec_rdata_o <= 8'h00;
    end
    else
    begin
      page_r <= page_nxt; // see RQ1
      spec_rdata_o <= page_hit ? page_r : 8'h00;
    end
  end

  // ****************************************
  // instruction cycle sequencer
  // ****************************************
  acd_pkg::acd_state_t state_r;
  acd_pkg::acd_state_t state_nxt;
  logic [CW-1:0] clk_cnt_r;
  logic [CW-1:0] clk_cnt_nxt;
  logic [3:0] icyc_cnt_r;
  logic [3:0] icyc_cnt_nxt;

  wire logic accept;
  wire logic last_clk;
  wire logic last_icyc;
  assign accept = start_i && (state_r == acd_pkg::ACD_ST_IDLE);
  assign last_clk = (clk_cnt_r == CW'(CLK_PER_ICYC - 1)); // see RQ21
  assign last_icyc = (icyc_cnt_r == cycle_count_o - 4'h1); // see RQ22
  assign busy_o = (state_r == acd_pkg::ACD_ST_EXEC);
  assign done_o = busy_o && last_clk && last_icyc;
  assign icyc_tick_o = busy_o && last_clk;

  always_comb
  begin
    state_nxt = state_r;
    clk_cnt_nxt = clk_cnt_r;
    icyc_cnt_nxt = icyc_cnt_r;
    unique case (state_r)
      acd_pkg::ACD_ST_IDLE:
      begin
        if (start_i)
        begin
          state_nxt = acd_pkg::ACD_ST_EXEC;
          clk_cnt_nxt = '0;
          icyc_cnt_nxt = 4'h0;
        end
      end
      acd_pkg::ACD_ST_EXEC:
      begin
        clk_cnt_nxt = last_clk ? '0 : clk_cnt_r + CW'(1);
        if (last_clk)
        begin
          icyc_cnt_nxt = icyc_cnt_r + 4'h1;
        end
        if (done_o)
        begin
          state_nxt = acd_pkg::ACD_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= acd_pkg::ACD_ST_IDLE;
      clk_cnt_r <= '0;
      icyc_cnt_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      clk_cnt_r <= clk_cnt_nxt;
      icyc_cnt_r <= icyc_cnt_nxt;
    end
  end

  // ****************************************
  // latched decode results
  // ****************************************
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      op_class_o <= acd_pkg::ACD_OTHER;
      byte_count_o <= 2'h1;
      cycle_count_o <= 4'h1;
      bank_sel_o <= 3'h0;
      ptr_sel_o <= 1'b0;
      uses_bank_o <= 1'b0;
      uses_ptr_o <= 1'b0;
      xaddr_o <= 16'h0000;
      xrd_o <= 1'b0;
      xwr_o <= 1'b0;
      periph_hit_o <= 1'b0;
      rel_target_o <= 16'h0000;
      abs_target_o <= 16'h0000;
      long_target_o <= 16'h0000;
    end
    else if (accept)
    begin
      op_class_o <= dec_class; // see RQ3
      byte_count_o <= dec_bytes;
      cycle_count_o <= dec_total; // see RQ22
      bank_sel_o <= opcode_i[2:0]; // see RQ23
      ptr_sel_o <= opcode_i[0]; // see RQ23
      uses_bank_o <= dec_bank;
      uses_ptr_o <= dec_ptr;
      xaddr_o <= dec_xaddr; // see RQ1 see RQ2
      xrd_o <= dec_is_x && !dec_xwrite; // see RQ24
      xwr_o <= dec_is_x && dec_xwrite; // see RQ24
      periph_hit_o <= dec_is_x && (dec_xaddr >= PERIPH_BASE); // see RQ4
      rel_target_o <= pc_i + rel_sext; // see RQ19
      abs_target_o <= {pc_i[15:11], opcode_i[7:5], operand1_i}; // see RQ20
      long_target_o <= {operand1_i, operand2_i}; // see RQ20
    end
    else if (done_o)
    begin
      xrd_o <= 1'b0;
      xwr_o <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [7:0] run_clk_r;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      run_clk_r <= 8'h00;
    end
    else
    begin
      run_clk_r <= accept ? 8'h00 : (busy_o ? run_clk_r + 8'h01 : run_clk_r);
    end
  end

  sequence s_accept_op(logic [7:0] pat_hi, logic [7:0] mask);
    accept && ((opcode_i & mask) == pat_hi);
  endsequence

  sequence s_decoded(logic [1:0] b, logic [3:0] c);
    (byte_count_o == b) && (cycle_count_o == c);
  endsequence

  chk_page_write: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ1
    spec_wr_i && page_hit |=> page_r == $past(spec_wdata_i))
    else $error("page register not written");
  chk_xaddr_page: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ1
    s_accept_op(8'he2, 8'hee) |=>
      xaddr_o == {$past(page_r), ($past(opcode_i[0]) ? $past(r1_i) : $past(r0_i))})
    else $error("narrow external address wrong");
  chk_xaddr_wide: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ2
    s_accept_op(8'he0, 8'hef) |=> xaddr_o == $past(data_ptr_i))
    else $error("wide external address wrong");
  chk_addc_bank: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ5
    s_accept_op(8'h38, 8'hf8) |=> s_decoded(2'h1, 4'h1) and
      (bank_sel_o == $past(opcode_i[2:0])) and (op_class_o == acd_pkg::ACD_ARITH))
    else $error("add with carry decode wrong");
  chk_subb_xrl: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ6 see RQ9
    s_accept_op(8'h98, 8'hf8) or s_accept_op(8'h68, 8'hf8) |=>
      s_decoded(2'h1, 4'h1) and uses_bank_o)
    else $error("bank register op decode wrong");
  chk_multi_cyc: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ8 see RQ11
    s_accept_op(8'h53, 8'hff) or s_accept_op(8'h85, 8'hff) or s_accept_op(8'h90, 8'hff)
      |=> s_decoded(2'h3, 4'h3))
    else $error("three byte op decode wrong");
  chk_one_byte_3: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ7 see RQ13
    s_accept_op(8'ha3, 8'hff) or s_accept_op(8'h93, 8'hff) or s_accept_op(8'h83, 8'hff)
      |=> s_decoded(2'h1, 4'h3))
    else $error("one byte three cycle decode wrong");
  chk_two_byte_2: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ17 see RQ18
    s_accept_op(8'hc0, 8'hff) or s_accept_op(8'h76, 8'hfe) |=> s_decoded(2'h2, 4'h2))
    else $error("two byte decode wrong");
  chk_xmove_len: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ15 see RQ16
    s_accept_op(8'he0, 8'hef) or s_accept_op(8'he2, 8'hee) |=>
      (cycle_count_o == 4'h2 + {1'b0, $past(stretch_i)}) and (xrd_o != xwr_o))
    else $error("external move length wrong");
  chk_icyc_len: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ21
    icyc_tick_o && !done_o |=> !icyc_tick_o [*3] ##1 icyc_tick_o)
    else $error("instruction cycle not four clocks");
  chk_done_time: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ22
    done_o |-> (run_clk_r == 8'(cycle_count_o * CLK_PER_ICYC - 1)))
    else $error("instruction length wrong");
  chk_xstrobe_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ24
    busy_o && (xrd_o || xwr_o) && !done_o |=> xrd_o || xwr_o)
    else $error("external strobe dropped early");
  chk_rel_target: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ19
    accept |=> rel_target_o == 16'($past(pc_i) + {{8{$past(operand1_i[7])}}, $past(operand1_i)}))
    else $error("relative target wrong");
  chk_abs_target: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see RQ20
    accept |=> abs_target_o[10:0] == {$past(opcode_i[7:5]), $past(operand1_i)} &&
      abs_target_o[15:11] == $past(pc_i[15:11]))
    else $error("short target wrong");
endmodule

// ### src/acd_len_table.sv
// opcode to class, byte count and cycle count table
`timescale 1ns/10ps
`include "acd_consts.svh"
module acd_len_table
(
  input wire logic [7:0] opcode_i,
  output acd_pkg::acd_class_t op_class_o,
  output logic [1:0] byte_count_o,
  output logic [3:0] cycle_count_o,
  output logic uses_bank_o,
  output logic uses_ptr_o,
  output logic xmove_write_o,
  output logic xmove_wide_o
);
  always_comb
  begin
    op_class_o = acd_pkg::ACD_OTHER;
    byte_count_o = 2'h1;
    cycle_count_o = 4'h1;
    casez (opcode_i)
      8'h04, 8'h14, 8'hd4, 8'h06, 8'h07, 8'h16, 8'h17, 8'h26, 8'h27, 8'h36, 8'h37,
      8'h96, 8'h97, 8'b000?_1???, 8'b0010_1???, `ACD_OP_ADDC_BANK, `ACD_OP_SUBB_BANK:
        op_class_o = acd_pkg::ACD_ARITH;
      8'h24, 8'h34, 8'h94, 8'h05, 8'h15, 8'h25, 8'h35, 8'h95:
      begin
        op_class_o = acd_pkg::ACD_ARITH;
        byte_count_o = 2'h2;
        cycle_count_o = 4'h2;
      end
      `ACD_OP_INC_DATA_PTR: // see RQ7
      begin
        op_class_o = acd_pkg::ACD_ARITH;
        cycle_count_o = 4'h3;
      end
      8'ha4, 8'h84:
      begin
        op_class_o = acd_pkg::ACD_ARITH;
        cycle_count_o = 4'h5;
      end
      8'h42, 8'h52, 8'h62, 8'h44, 8'h54, 8'h64, 8'h45, 8'h55, 8'h65:
      begin
        op_class_o = acd_pkg::ACD_LOGIC;
        byte_count_o = 2'h2;
        cycle_count_o = 4'h2;
      end
      8'h43, `ACD_OP_ANL_DIR_IMM, 8'h63:
      begin
        op_class_o = acd_pkg::ACD_LOGIC;
        byte_count_o = 2'h3;
        cycle_count_o = 4'h3;
      end
      8'h46, 8'h47, 8'h56, 8'h57, 8'h66, 8'h67, 8'b010?_1???, `ACD_OP_XRL_BANK,
      8'he4, 8'hf4, 8'hc4, 8'h23, `ACD_OP_RLC, 8'h03, `ACD_OP_RRC: // see RQ9 see RQ10
        op_class_o = acd_pkg::ACD_LOGIC;
      8'he5, 8'h74, 8'hf5, `ACD_OP_PUSH, 8'hd0, 8'hc5, 8'b1010_1???, 8'b0111_1???,
      8'b1000_1???, 8'h86, 8'h87, 8'ha6, 8'ha7, `ACD_OP_MOV_IND_IMM:
      begin
        op_class_o = acd_pkg::ACD_MOVE;
        byte_count_o = 2'h2;
        cycle_count_o = 4'h2;
      end
      `ACD_OP_MOV_DIR_DIR, 8'h75, `ACD_OP_MOV_PTR_IMM: // see RQ11 see RQ12
      begin
        op_class_o = acd_pkg::ACD_MOVE;
        byte_count_o = 2'h3;
        cycle_count_o = 4'h3;
      end
      `ACD_OP_CODE_VIA_PTR, `ACD_OP_CODE_PC: // see RQ13 see RQ14
      begin
        op_class_o = acd_pkg::ACD_CODERD;
        cycle_count_o = 4'h3;
      end
      8'he2, 8'he3, `ACD_OP_XRD_WIDE, `ACD_OP_XWR_PTR, 8'hf0:
      begin
        op_class_o = acd_pkg::ACD_XMOVE;
        cycle_count_o = `ACD_XMOVE_BASE_CYC;
      end
      8'b111?_1???, 8'he6, 8'he7, 8'hf6, 8'hf7, 8'b1100_1???, 8'hc6, 8'hc7, 8'hd6, 8'hd7:
        op_class_o = acd_pkg::ACD_MOVE;
      default:
        op_class_o = acd_pkg::ACD_OTHER;
    endcase
  end

  // register-use flags from opcode bits 3 to 1 and the class, external-move flags straight from bits 4 and 1
  assign uses_bank_o = opcode_i[3] && (op_class_o != acd_pkg::ACD_OTHER);
  assign uses_ptr_o = (op_class_o != acd_pkg::ACD_OTHER) && !opcode_i[3] &&
    ((opcode_i[2:1] == 2'b11) || ((op_class_o == acd_pkg::ACD_XMOVE) && opcode_i[1]));
  assign xmove_write_o = opcode_i[4];
  assign xmove_wide_o = !opcode_i[1];
endmodule

// ### src/acd_pkg.sv
// types for the instruction decode block
package acd_pkg;
  typedef enum logic [2:0] {
    ACD_OTHER,
    ACD_ARITH,
    ACD_LOGIC,
    ACD_MOVE,
    ACD_XMOVE,
    ACD_CODERD
  } acd_class_t;
  typedef enum logic {
    ACD_ST_IDLE,
    ACD_ST_EXEC
  } acd_state_t;
endpackage

// ### src/acd_xaddr.sv
// external data address former
`timescale 1ns/10ps
module acd_xaddr
(
  input wire logic wide_i,
  input wire logic ptr_sel_i,
  input wire logic [7:0] r0_i,
  input wire logic [7:0] r1_i,
  input wire logic [7:0] page_i,
  input wire logic [15:0] data_ptr_i,
  output logic [15:0] xaddr_o
);
  wire logic [7:0] low_byte;
  assign low_byte = ptr_sel_i ? r1_i : r0_i; // see RQ1
  assign xaddr_o = wide_i ? data_ptr_i : {page_i, low_byte}; // see RQ1 see RQ2
endmodule
